/* src/ptcfs_top.sv */
// ptcfs_top: motor thermistor protection and malfunction snapshot
// registers behind an axi4-lite slave.
// assumes analog readings, live drive values and the malfunction
// strobe come from logic on clk_i, so they pass no synchroniser.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module ptcfs_top
#(
  parameter int AI_WIDTH = 12,
  parameter int ADDR_W   = 16
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  // axi4-lite write address
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr_i,
  input  wire logic [2:0]            s_axi_awprot_i,
  // axi4-lite write data
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  // axi4-lite write response
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  output logic [1:0]                 s_axi_bresp_o,
  // axi4-lite read address
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr_i,
  input  wire logic [2:0]            s_axi_arprot_i,
  // axi4-lite read data
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  // analog readings
  input  wire logic [AI_WIDTH-1:0]   analog_input_one_i,
  input  wire logic [AI_WIDTH-1:0]   analog_input_two_i,
  // live drive values
  input  wire logic                  malfunction_i,
  input  wire logic [15:0]           freq_command_i,
  input  wire logic [15:0]           output_freq_i,
  input  wire logic [15:0]           output_voltage_i,
  input  wire logic [15:0]           link_voltage_i,
  input  wire logic [15:0]           output_current_i,
  input  wire logic [15:0]           switch_temperature_i,
  input  wire logic [15:0]           motor_speed_i,
  input  wire logic [15:0]           torque_command_i,
  input  wire logic [15:0]           input_terminals_i,
  input  wire logic [15:0]           output_terminals_i,
  input  wire logic [15:0]           drive_status_i,
  // protection outputs
  output logic                       motor_overheat_warning_o,
  output logic                       thermistor_fault_o,
  output logic                       ramp_stop_o,
  output logic                       coast_stop_o,
  output logic [7:0]                 fault_code_o,
  output logic [7:0]                 fault_category_o,
  output logic                       snapshot_taken_o
);
  import ptcfs_pkg::*;

  // ****************************************************************
  // software registers
  // ****************************************************************
  logic [15:0] action_select;
  logic [15:0] trip_level;
  logic [15:0] ai_one_func;
  logic [15:0] ai_two_func;
  logic [15:0] snap [SNAP_COUNT];
  logic        fault_reset_cmd;

  // ****************************************************************
  // axi write channel state
  // ****************************************************************
  logic              aw_held;
  logic [13:0]       aw_index;
  logic              w_held;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              bvalid;
  logic [1:0]        bresp;
  logic              do_write;
  logic              wr_mapped;

  assign s_axi_awready_o = !aw_held && !bvalid;
  assign s_axi_wready_o  = !w_held && !bvalid;
  assign s_axi_bvalid_o  = bvalid;
  assign s_axi_bresp_o   = bresp;
  assign do_write        = aw_held && w_held && !bvalid;

  // address and data are taken in either order, one write at a time
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held  <= 1'b0;
      aw_index <= 14'h0000;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held  <= 1'b1;
      aw_index <= s_axi_awaddr_i[15:2];
    end else if (do_write) begin
      aw_held  <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    case (aw_index)
      IDX_ACTION_SELECT, IDX_TRIP_LEVEL, IDX_AI_ONE_FUNC,
      IDX_AI_TWO_FUNC, IDX_FAULT_CONTROL, IDX_FAULT_FREQ_CMD,
      IDX_FAULT_OUT_FREQ, IDX_FAULT_OUT_VOLT, IDX_FAULT_LINK_VOLT,
      IDX_FAULT_OUT_CURR, IDX_FAULT_SW_TEMP, IDX_FAULT_SPEED,
      IDX_FAULT_TORQUE, IDX_FAULT_IN_TERM, IDX_FAULT_OUT_TERM,
      IDX_FAULT_STATUS, IDX_FAULT_REPORT, IDX_LIVE_STATUS:
        wr_mapped = 1'b1;
      default:
        wr_mapped = 1'b0;
    endcase
  end

  // read-only words answer okay and keep their value
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // writable registers
  // ****************************************************************
  function automatic logic [15:0] merge(input logic [15:0] old_val,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    return {strb[1] ? data[15:8] : old_val[15:8],
            strb[0] ? data[7:0] : old_val[7:0]};
  endfunction

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      action_select <= RST_ACTION_SELECT;
      trip_level    <= RST_TRIP_LEVEL;
      ai_one_func   <= RST_AI_FUNC;
      ai_two_func   <= RST_AI_FUNC;
    end else if (do_write) begin
      case (aw_index)
        IDX_ACTION_SELECT: begin
          action_select <= merge(action_select, w_data, w_strb);
        end
        IDX_TRIP_LEVEL: begin
          trip_level <= merge(trip_level, w_data, w_strb);
        end
        IDX_AI_ONE_FUNC: begin
          ai_one_func <= merge(ai_one_func, w_data, w_strb);
        end
        IDX_AI_TWO_FUNC: begin
          ai_two_func <= merge(ai_two_func, w_data, w_strb);
        end
        default: begin
        end
      endcase
    end
  end

  // one-cycle reset command from the control word
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_reset_cmd <= 1'b0;
    end else begin
      fault_reset_cmd <= do_write && (aw_index == IDX_FAULT_CONTROL)
                         && w_strb[0] && w_data[CTRL_RESET_BIT];
    end
  end

  // ****************************************************************
  // thermistor comparison
  // ****************************************************************
  logic              source_valid;
  logic [AI_WIDTH-1:0] reading;
  logic [15:0]       level_clamped;
  logic [31:0]       reading_scaled;
  logic [31:0]       level_scaled;
  logic              trip;
  logic [1:0]        action;

  assign action = action_select[1:0];
  always_comb begin
    if (ai_one_func == AI_FUNC_THERMISTOR) begin
      source_valid = 1'b1;
      reading      = analog_input_one_i;
    end else if (ai_two_func == AI_FUNC_THERMISTOR) begin
      source_valid = 1'b1;
      reading      = analog_input_two_i;
    end else begin
      source_valid = 1'b0;
      reading      = '0;
    end
  end

  // cross-multiplied so no divider is needed in the compare
  always_comb begin
    level_clamped = (trip_level > LEVEL_FULL_SCALE) ? LEVEL_FULL_SCALE
                                                    : trip_level;
    reading_scaled = 32'(reading) * 32'(LEVEL_FULL_SCALE);
    level_scaled   = 32'(level_clamped) * 32'((2 ** AI_WIDTH) - 1);
    trip           = source_valid && (reading_scaled >= level_scaled);
  end

  // ****************************************************************
  // overheat fault latch
  // ****************************************************************
  logic thermistor_fault;
  logic fault_coast;
  logic fault_set;
  assign fault_set = trip && !thermistor_fault
                     && (action == ACT_RAMP || action == ACT_COAST);

  // a trip in the reset cycle keeps the fault: clear needs no trip
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      thermistor_fault <= 1'b0;
      fault_coast      <= 1'b0;
    end else if (fault_set) begin
      thermistor_fault <= 1'b1;
      fault_coast      <= (action == ACT_COAST);
    end else if (fault_reset_cmd && !trip) begin
      thermistor_fault <= 1'b0;
      fault_coast      <= 1'b0;
    end
  end

  // ****************************************************************
  // protection outputs
  // ****************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      motor_overheat_warning_o <= 1'b0;
      thermistor_fault_o       <= 1'b0;
      ramp_stop_o              <= 1'b0;
      coast_stop_o             <= 1'b0;
      fault_code_o             <= 8'h00;
      fault_category_o         <= 8'h00;
    end else begin
      motor_overheat_warning_o <= (action != ACT_WARN)
                                  && (trip || thermistor_fault);
      thermistor_fault_o       <= thermistor_fault;
      ramp_stop_o              <= thermistor_fault && !fault_coast;
      coast_stop_o             <= thermistor_fault && fault_coast;
      fault_code_o             <= thermistor_fault
                                  ? FAULT_CODE_THERMISTOR : 8'h00;
      fault_category_o         <= thermistor_fault
                                  ? 8'(1 << CATEGORY_OVERLOAD_BIT)
                                  : 8'h00;
    end
  end

  // ****************************************************************
  // malfunction snapshot
  // ****************************************************************
  logic capture;
  // either an outside malfunction or our own overheat fault being set (ramp or coast action only)
  assign capture = malfunction_i || fault_set;

  // one edge for the whole record keeps it consistent
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < SNAP_COUNT; i++) begin
        snap[i] <= RST_SNAPSHOT;
      end
    end else if (capture) begin
      snap[0]  <= freq_command_i;
      snap[1]  <= output_freq_i;
      snap[2]  <= output_voltage_i;
      snap[3]  <= link_voltage_i;
      snap[4]  <= output_current_i;
      snap[5]  <= switch_temperature_i;
      snap[6]  <= motor_speed_i;
      snap[7]  <= torque_command_i;
      snap[8]  <= input_terminals_i;
      snap[9]  <= output_terminals_i;
      snap[10] <= drive_status_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      snapshot_taken_o <= 1'b0;
    end else begin
      snapshot_taken_o <= capture;
    end
  end

  // ****************************************************************
  // axi read channel
  // ****************************************************************
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic [15:0] rd_word;
  logic        rd_mapped;
  logic [15:0] report_word;

  assign s_axi_arready_o = !rvalid;
  assign s_axi_rvalid_o  = rvalid;
  assign s_axi_rdata_o   = rdata;
  assign s_axi_rresp_o   = rresp;

  always_comb begin
    report_word = 16'h0000;
    report_word[REPORT_CODE_LSB +: 8] = fault_code_o;
    report_word[REPORT_FAULT_BIT]     = thermistor_fault;
    report_word[REPORT_TRIP_BIT]      = trip;
    report_word[REPORT_WARN_BIT]      = motor_overheat_warning_o;
  end

  // snapshot words only ever come from reset or the capture above
  always_comb begin
    rd_mapped = 1'b1;
    case (s_axi_araddr_i[15:2])
      IDX_ACTION_SELECT:   rd_word = action_select;
      IDX_TRIP_LEVEL:      rd_word = trip_level;
      IDX_AI_ONE_FUNC:     rd_word = ai_one_func;
      IDX_AI_TWO_FUNC:     rd_word = ai_two_func;
      IDX_FAULT_CONTROL:   rd_word = 16'h0000;
      IDX_FAULT_REPORT:    rd_word = report_word;
      IDX_FAULT_FREQ_CMD:  rd_word = snap[0];
      IDX_FAULT_OUT_FREQ:  rd_word = snap[1];
      IDX_FAULT_OUT_VOLT:  rd_word = snap[2];
      IDX_FAULT_LINK_VOLT: rd_word = snap[3];
      IDX_FAULT_OUT_CURR:  rd_word = snap[4];
      IDX_FAULT_SW_TEMP:   rd_word = snap[5];
      IDX_FAULT_SPEED:     rd_word = snap[6];
      IDX_FAULT_TORQUE:    rd_word = snap[7];
      IDX_FAULT_IN_TERM:   rd_word = snap[8];
      IDX_FAULT_OUT_TERM:  rd_word = snap[9];
      IDX_FAULT_STATUS:    rd_word = snap[10];
      IDX_LIVE_STATUS:     rd_word = drive_status_i;
      default: begin
        rd_word   = 16'h0000;
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid_i && !rvalid) begin
      rvalid <= 1'b1;
      rdata  <= {16'h0000, rd_word};
      rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid <= 1'b0;
    end
  end

endmodule

/* inc/ptcfs_pkg.sv */
// ptcfs_pkg: register indices, field positions, reset values and codes
// for the thermistor protection and fault snapshot register bank.
// assumes word-indexed registers; byte address is four times the index.
package ptcfs_pkg;

  // ****************************************************************
  // register indices (byte address = index * 4)
  // ****************************************************************
  localparam logic [13:0] IDX_ACTION_SELECT   = 14'h061d;
  localparam logic [13:0] IDX_TRIP_LEVEL      = 14'h061e;
  localparam logic [13:0] IDX_FAULT_FREQ_CMD  = 14'h061f;
  localparam logic [13:0] IDX_FAULT_OUT_FREQ  = 14'h0620;
  localparam logic [13:0] IDX_FAULT_OUT_VOLT  = 14'h0621;
  localparam logic [13:0] IDX_FAULT_LINK_VOLT = 14'h0622;
  localparam logic [13:0] IDX_FAULT_OUT_CURR  = 14'h0623;
  localparam logic [13:0] IDX_FAULT_SW_TEMP   = 14'h0624;
  localparam logic [13:0] IDX_FAULT_SPEED     = 14'h0626;
  localparam logic [13:0] IDX_FAULT_TORQUE    = 14'h0627;
  localparam logic [13:0] IDX_FAULT_IN_TERM   = 14'h0628;
  localparam logic [13:0] IDX_FAULT_OUT_TERM  = 14'h0629;
  localparam logic [13:0] IDX_FAULT_STATUS    = 14'h062a;
  localparam logic [13:0] IDX_AI_ONE_FUNC     = 14'h0300;
  localparam logic [13:0] IDX_AI_TWO_FUNC     = 14'h0301;
  localparam logic [13:0] IDX_FAULT_CONTROL   = 14'h0700;
  localparam logic [13:0] IDX_FAULT_REPORT    = 14'h0701;
  localparam logic [13:0] IDX_LIVE_STATUS     = 14'h2101;

  // ****************************************************************
  // reset values, codes and fields
  // ****************************************************************
  localparam logic [15:0] RST_ACTION_SELECT = 16'h0000;
  localparam logic [15:0] RST_TRIP_LEVEL    = 16'h01f4;
  localparam logic [15:0] RST_AI_FUNC       = 16'h0000;
  localparam logic [15:0] RST_SNAPSHOT      = 16'h0000;
  localparam logic [15:0] AI_FUNC_THERMISTOR = 16'h0006;
  localparam logic [1:0]  ACT_WARN  = 2'h0;
  localparam logic [1:0]  ACT_RAMP  = 2'h1;
  localparam logic [1:0]  ACT_COAST = 2'h2;
  localparam logic [1:0]  ACT_NONE  = 2'h3;
  localparam logic [15:0] LEVEL_FULL_SCALE = 16'h03e8;
  localparam logic [7:0]  FAULT_CODE_THERMISTOR = 8'h18;
  localparam int          CATEGORY_OVERLOAD_BIT = 2;
  localparam int          CTRL_RESET_BIT = 0;
  localparam int          REPORT_CODE_LSB = 0;
  localparam int          REPORT_FAULT_BIT = 8;
  localparam int          REPORT_TRIP_BIT = 9;
  localparam int          REPORT_WARN_BIT = 10;
  localparam int          SNAP_COUNT = 11;

  // ****************************************************************
  // axi responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* testbench/ptcfs_top_asserts.sv */
// ptcfs_top_asserts: port-level checks for the protection register bank.
// assumes it is bound into ptcfs_top and that all logic runs on clk_i.
`timescale 1ns/1ps
module ptcfs_top_asserts
  import ptcfs_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  // register bus
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  // protection and capture
  input wire logic        malfunction_i,
  input wire logic        snapshot_taken_o,
  input wire logic        thermistor_fault_o,
  input wire logic        ramp_stop_o,
  input wire logic        coast_stop_o,
  input wire logic [7:0]  fault_code_o,
  input wire logic [7:0]  fault_category_o
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence ar_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  sequence r_wait;
    s_axi_rvalid_o && !s_axi_rready_i;
  endsequence
  a_snap_pulse: assert property (
    malfunction_i |=> snapshot_taken_o)
    else $error("capture pulse missing");
  a_fault_code: assert property (
    fault_code_o == (thermistor_fault_o ? FAULT_CODE_THERMISTOR : 8'h00))
    else $error("fault code wrong");
  a_fault_class: assert property (
    fault_category_o == (thermistor_fault_o ? 8'h04 : 8'h00))
    else $error("fault category wrong");
  a_stop_kind: assert property (
    (ramp_stop_o || coast_stop_o) |->
      thermistor_fault_o && !(ramp_stop_o && coast_stop_o))
    else $error("stop kind wrong");
  a_read_answer: assert property (
    ar_take |=> s_axi_rvalid_o && (s_axi_rdata_o[31:16] == 16'h0000))
    else $error("read answer late or wide");
  a_read_hold: assert property (
    r_wait |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  a_resp_hold: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=>
      s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  a_write_block: assert property (
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken during response");
endmodule

bind ptcfs_top ptcfs_top_asserts chk_u (.*);

/* testbench/ptcfs_host.sv */
// ptcfs_host: axi4-lite host model, one write and one read at a time.
// assumes the bench calls wr and rd; waits end only by the watchdog.
`timescale 1ns/1ps
module ptcfs_host (
  // clock
  input  wire logic        clk_i,
  // master outputs
  output logic             awvalid_o = 1'b0,
  output logic [15:0]      awaddr_o = 16'h0000,
  output logic             wvalid_o = 1'b0,
  output logic [31:0]      wdata_o = 32'h0000_0000,
  output logic             bready_o = 1'b0,
  output logic             arvalid_o = 1'b0,
  output logic [15:0]      araddr_o = 16'h0000,
  output logic             rready_o = 1'b0,
  // slave answers
  input  wire logic        awready_i,
  input  wire logic        wready_i,
  input  wire logic        bvalid_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        arready_i,
  input  wire logic        rvalid_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i
);
  // ****************************************************************
  // bus cycles
  // ****************************************************************
  // each channel is released at its own edge; slave may take either first
  task automatic wr(input logic [13:0] idx, input logic [31:0] d,
                    output logic [1:0] resp);
    logic aw_left;
    logic w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    @(posedge clk_i);
    awaddr_o <= {idx, 2'h0};
    wdata_o <= d;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    while (aw_left || w_left) begin
      @(posedge clk_i);
      if (aw_left && awready_i) begin
        aw_left = 1'b0;
        awvalid_o <= 1'b0;
      end
      if (w_left && wready_i) begin
        w_left = 1'b0;
        wvalid_o <= 1'b0;
      end
    end
    while (!bvalid_i) @(posedge clk_i);
    resp = bresp_i;
    bready_o <= 1'b0;
  endtask
  task automatic rd(input logic [13:0] idx, output logic [31:0] d,
                    output logic [1:0] resp);
    @(posedge clk_i);
    araddr_o <= {idx, 2'h0};
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do @(posedge clk_i); while (!arready_i);
    arvalid_o <= 1'b0;
    while (!rvalid_i) @(posedge clk_i);
    d = rdata_i;
    resp = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule

/* testbench/test_ptc_protect_fault_snapshot.sv */
// test_ptc_protect_fault_snapshot: register, capture and trip tests.
// assumes ptcfs_host speaks the bus and the checker is bound to the top.
`timescale 1ns/1ps
module test_ptc_protect_fault_snapshot;
  import ptcfs_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
  logic        s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
  logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
  logic        s_axi_rready_i, malfunction_i = 1'b0;
  logic [15:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [2:0]  s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0;
  logic [3:0]  s_axi_wstrb_i = 4'hf;
  logic [11:0] analog_input_one_i = 12'h800, analog_input_two_i = 12'h000;
  logic        motor_overheat_warning_o, thermistor_fault_o, ramp_stop_o;
  logic        coast_stop_o, snapshot_taken_o;
  logic [7:0]  fault_code_o, fault_category_o;
  logic [15:0] live [11] = '{default: 16'h0000};
  logic [15:0] base [2] = '{16'h8000, 16'h1234};
  logic [13:0] snap_idx [11] = '{IDX_FAULT_FREQ_CMD, IDX_FAULT_OUT_FREQ,
    IDX_FAULT_OUT_VOLT, IDX_FAULT_LINK_VOLT, IDX_FAULT_OUT_CURR,
    IDX_FAULT_SW_TEMP, IDX_FAULT_SPEED, IDX_FAULT_TORQUE,
    IDX_FAULT_IN_TERM, IDX_FAULT_OUT_TERM, IDX_FAULT_STATUS};
  wire  [3:0]  outs = {motor_overheat_warning_o, thermistor_fault_o,
                       ramp_stop_o, coast_stop_o};
  int          err_total = 0;
  int          checks_done = 0;

  ptcfs_top dut_u (.*,
    .freq_command_i(live[0]), .output_freq_i(live[1]),
    .output_voltage_i(live[2]), .link_voltage_i(live[3]),
    .output_current_i(live[4]), .switch_temperature_i(live[5]),
    .motor_speed_i(live[6]), .torque_command_i(live[7]),
    .input_terminals_i(live[8]), .output_terminals_i(live[9]),
    .drive_status_i(live[10]));
  ptcfs_host host_u (.clk_i(clk_i),
    .awvalid_o(s_axi_awvalid_i), .awaddr_o(s_axi_awaddr_i),
    .wvalid_o(s_axi_wvalid_i), .wdata_o(s_axi_wdata_i),
    .bready_o(s_axi_bready_i), .arvalid_o(s_axi_arvalid_i),
    .araddr_o(s_axi_araddr_i), .rready_o(s_axi_rready_i),
    .awready_i(s_axi_awready_o), .wready_i(s_axi_wready_o),
    .bvalid_i(s_axi_bvalid_o), .bresp_i(s_axi_bresp_o),
    .arready_i(s_axi_arready_o), .rvalid_i(s_axi_rvalid_o),
    .rdata_i(s_axi_rdata_o), .rresp_i(s_axi_rresp_o));

  always #10 clk_i = ~clk_i;

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp,
                        input logic [1:0] rexp);
    logic [31:0] d;
    logic [1:0]  r;
    host_u.rd(idx, d, r);
    check($sformatf("data %h", idx), d, exp);
    check($sformatf("resp %h", idx), {30'h0, r}, {30'h0, rexp});
  endtask
  // live values move right after the capture edge, so a late load shows
  task automatic capture(input logic [15:0] b);
    @(posedge clk_i);
    for (int k = 0; k < 11; k++) live[k] <= b + 16'(k) * 16'h0123;
    malfunction_i <= 1'b1;
    @(posedge clk_i);
    malfunction_i <= 1'b0;
    for (int k = 0; k < 11; k++) live[k] <= ~(b + 16'(k) * 16'h0123);
  endtask

  initial begin
    #100000;
    err_total++;
    stop_test();
  end

  initial begin
    logic [1:0] r;
    logic       flt;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd_chk(IDX_ACTION_SELECT, 32'h0, RESP_OKAY);
    rd_chk(IDX_TRIP_LEVEL, {16'h0, RST_TRIP_LEVEL}, RESP_OKAY);
    for (int k = 0; k < 11; k++) rd_chk(snap_idx[k], 32'h0, RESP_OKAY);
    $display("test reset values done");
    for (int p = 0; p < 2; p++) begin
      capture(base[p]);
      for (int k = 0; k < 11; k++) begin
        rd_chk(snap_idx[k], {16'h0, base[p] + 16'(k) * 16'h0123},
               RESP_OKAY);
      end
      rd_chk(IDX_LIVE_STATUS, {16'h0, live[10]}, RESP_OKAY);
    end
    $display("test capture done");
    for (int k = 0; k < 11; k++) begin
      host_u.wr(snap_idx[k], 32'hffff, r);
      check("write resp", {30'h0, r}, {30'h0, RESP_OKAY});
      rd_chk(snap_idx[k], {16'h0, base[1] + 16'(k) * 16'h0123},
             RESP_OKAY);
    end
    host_u.wr(14'h0625, 32'h1, r);
    check("gap write", {30'h0, r}, {30'h0, RESP_SLVERR});
    rd_chk(14'h0625, 32'h0, RESP_SLVERR);
    $display("test read only done");
    host_u.wr(IDX_AI_ONE_FUNC, 32'h5, r);
    host_u.wr(IDX_ACTION_SELECT, {30'h0, ACT_RAMP}, r);
    tick(4);
    check("other function", {28'h0, outs}, 32'h0);
    analog_input_one_i <= 12'h7ff;
    host_u.wr(IDX_AI_ONE_FUNC, {16'h0, AI_FUNC_THERMISTOR}, r);
    for (int a = 0; a < 4; a++) begin
      host_u.wr(IDX_ACTION_SELECT, 32'(a), r);
      tick(4);
      check("below level", {28'h0, outs}, 32'h0);
      analog_input_one_i <= 12'h800;
      tick(4);
      flt = (a == 1) || (a == 2);
      check("action", {28'h0, outs},
            {28'h0, a != 0, flt, a == 1, a == 2});
      check("code", {24'h0, fault_code_o}, flt ? 32'h18 : 32'h0);
      check("class", {24'h0, fault_category_o}, flt ? 32'h4 : 32'h0);
      if (flt) begin
        rd_chk(IDX_FAULT_FREQ_CMD, {16'h0, live[0]}, RESP_OKAY);
        host_u.wr(IDX_FAULT_CONTROL, 32'h1, r);
        tick(4);
        check("held", {31'h0, thermistor_fault_o}, 32'h1);
      end
      analog_input_one_i <= 12'h7ff;
      host_u.wr(IDX_FAULT_CONTROL, 32'h1, r);
      tick(4);
      check("cleared", {28'h0, outs}, 32'h0);
    end
    $display("test thermistor done");
    host_u.wr(IDX_AI_ONE_FUNC, 32'h0, r);
    host_u.wr(IDX_AI_TWO_FUNC, {16'h0, AI_FUNC_THERMISTOR}, r);
    analog_input_two_i <= 12'h800;
    tick(4);
    check("second input", {28'h0, outs}, 32'h8);
    host_u.wr(IDX_TRIP_LEVEL, 32'hffff, r);
    tick(4);
    check("clamped level", {28'h0, outs}, 32'h0);
    analog_input_two_i <= 12'hfff;
    tick(4);
    check("full scale", {28'h0, outs}, 32'h8);
    reset_n_i <= 1'b0;
    tick(2);
    reset_n_i <= 1'b1;
    rd_chk(IDX_FAULT_STATUS, 32'h0, RESP_OKAY);
    $display("test second input done");
    stop_test();
  end
endmodule
